// ===== ssla_pkg.sv
// Shared constants for the secondary-side logic array of a programmable DC supply.
// Assumes one 100 MHz clock and that all pins are synchronous to it.

`default_nettype none

package ssla_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CONV_HALF_NS     = 20;
  localparam int CONV_HALF_CYC    = (CONV_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_NS          = 1000000;
  localparam int POLL_CYC         = POLL_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame and converter word layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS       = 24;
  localparam int CONV_BITS        = 16;
  localparam int OP_MSB           = 23;
  localparam int OP_LSB           = 20;
  localparam int ADDR_MSB         = 19;
  localparam int ADDR_LSB         = 16;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_DAC_WRITE  = 4'h1;
  localparam logic [3:0] OP_PREC_READ  = 4'h2;
  localparam logic [3:0] OP_AUX_READ   = 4'h3;
  localparam logic [3:0] OP_STATUS     = 4'h4;
  localparam logic [3:0] OP_PROT_CLEAR = 4'h5;
  localparam logic [3:0] OP_CAL_UNLOCK = 4'h6;
  localparam logic [3:0] OP_CAL_WRITE  = 4'h7;
  localparam logic [3:0] OP_CAL_READ   = 4'h8;
  localparam logic [3:0] OP_OUTPUT     = 4'h9;

  // ----------------------------------------------------------------
  // Converter selects and channels
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_DAC12     = 2'h0;
  localparam logic [1:0] DEV_DAC8      = 2'h1;
  localparam logic [1:0] DEV_ADC16     = 2'h2;
  localparam logic [1:0] DEV_ADC8      = 2'h3;
  localparam logic [1:0] DAC8_CH_OV    = 2'h0;
  localparam logic [1:0] DAC8_CH_FAN   = 2'h1;
  localparam logic [2:0] AUX_CH_CURR   = 3'h0;
  localparam logic [2:0] AUX_CH_VOLT   = 3'h1;
  localparam logic [2:0] AUX_CH_AMB    = 3'h2;
  localparam logic [2:0] AUX_CH_HS     = 3'h3;
  localparam logic [2:0] AUX_CH_FUSE   = 3'h4;
  localparam logic [2:0] SCAN_FAN_STEP = 3'h5;
  localparam logic [7:0] FUSE_OPEN_LVL = 8'h40;

  // ----------------------------------------------------------------
  // Status bits, calibration store, reset values
  // ----------------------------------------------------------------
  localparam int ST_CV        = 0;
  localparam int ST_CC        = 1;
  localparam int ST_OV        = 2;
  localparam int ST_OV_LATCH  = 3;
  localparam int ST_UNLOCKED  = 4;
  localparam int ST_CKSUM_OK  = 5;
  localparam int ST_FUSE_OPEN = 6;
  localparam int ST_OUT_OFF   = 7;
  localparam logic [3:0] CKSUM_ADDR     = 4'hF;
  localparam logic       OUT_OFF_RESET  = 1'b1;

endpackage : ssla_pkg

`default_nettype wire

// ===== ssla_conv_xfer.sv
// Shift engine for the shared converter bus of four chip-selected devices.
// Assumes devices latch on the rising serial clock edge, most significant bit first.
`timescale 1ns/1ps
`default_nettype none

module ssla_conv_xfer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [1:0]  dev,
  input  wire logic [15:0] word,
  input  wire logic        miso,
  output logic             sclk,
  output logic             mosi,
  output logic [3:0]       cs_n,
  output logic [15:0]      rx_word,
  output logic             done
);

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b01,
    XS_SHIFT = 2'b10
  } ssla_xstate_t;

  typedef struct packed {
    ssla_xstate_t state;
    logic [15:0]  tx;
    logic [15:0]  rx;
    logic [4:0]   bits;
    logic [7:0]   div;
    logic         sclk;
    logic [3:0]   cs_n;
    logic         done;
  } ssla_xfer_t;

  ssla_xfer_t q;
  ssla_xfer_t d;

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.state)
      XS_IDLE: begin
        if (start) begin
          d.cs_n  = ~(4'h1 << dev);
          d.tx    = word;
          d.bits  = 5'h00;
          d.div   = 8'h00;
          d.sclk  = 1'b0;
          d.state = XS_SHIFT;
        end
      end
      XS_SHIFT: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(ssla_pkg::CONV_HALF_CYC - 1)) begin
          d.div = 8'h00;
          if (!q.sclk) begin
            d.sclk = 1'b1;
            d.rx   = {q.rx[14:0], miso};
            d.bits = q.bits + 5'h01;
          end else begin
            d.sclk = 1'b0;
            if (q.bits == 5'(ssla_pkg::CONV_BITS)) begin
              d.cs_n  = 4'hF;
              d.done  = 1'b1;
              d.state = XS_IDLE;
            end else begin
              d.tx = {q.tx[14:0], 1'b0};
            end
          end
        end
      end
    endcase
    if (rst) begin
      d       = '0;
      d.state = XS_IDLE;
      d.cs_n  = 4'hF;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign sclk    = q.sclk;
  assign mosi    = q.tx[15];
  assign cs_n    = q.cs_n;
  assign rx_word = q.rx;
  assign done    = q.done;

endmodule : ssla_conv_xfer

`default_nettype wire

// ===== ssla_top.sv
// Secondary-side logic array: primary serial link, converter control, protection, fan.
// Assumes the isolated primary link and all status lines are synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

module ssla_top #(
  parameter int          POLL_CYCLES  = ssla_pkg::POLL_CYC,
  parameter logic [15:0] CAL_PASSWORD = 16'h5A5A
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PRI_CS_N,
  input  wire logic        PRI_SCLK,
  input  wire logic        PRI_SDI,
  output logic             PRI_SDO,
  output logic             PRI_BUSY,
  output logic             CONV_SCLK,
  output logic             CONV_MOSI,
  input  wire logic        CONV_MISO,
  output logic [3:0]       CONV_CS_N,
  output logic [1:0]       PREC_MUX_SEL,
  input  wire logic        CONST_VOLTAGE_FLAG_N,
  input  wire logic        CONST_CURRENT_FLAG_N,
  input  wire logic        OVERVOLTAGE_FLAG_N,
  input  wire logic        CAL_PROTECT,
  output logic             OUTPUT_SHUTDOWN,
  output logic             CROWBAR_FIRE_N,
  output logic [15:0]      STATUS
);

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_WAIT = 2'b10
  } ssla_mstate_t;

  typedef struct packed {
    ssla_mstate_t       state;
    logic               sclk_prev;
    logic               cs_n_prev;
    logic [23:0]        rx;
    logic [23:0]        tx;
    logic [4:0]         cnt;
    logic               pend;
    logic [23:0]        cmd;
    logic               job_host;
    logic [2:0]         step;
    logic [1:0]         mux;
    logic [4:0][7:0]    aux;
    logic               ov_latch;
    logic               out_off;
    logic               shutdown;
    logic               crowbar_n;
    logic               unlocked;
    logic [15:0][15:0]  cal;
    logic [15:0]        reply;
    logic [15:0]        status;
    logic [31:0]        poll;
    logic               start;
    logic [1:0]         dev;
    logic [15:0]        word;
  } ssla_main_t;

  ssla_main_t  q;
  ssla_main_t  d;
  logic        conv_done;
  logic [15:0] conv_rx;
  logic [3:0]  op;
  logic [3:0]  addr;
  logic [15:0] val;
  logic [7:0]  temp_max;
  logic [9:0]  fan_sum;
  logic [7:0]  fan_drive;
  logic [15:0] cksum;
  logic        cksum_ok;
  logic        fuse_open;

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  always_comb begin
    cksum = 16'h0000;
    for (int i = 0; i < 15; i++) begin
      cksum = cksum + q.cal[i];
    end
  end

  assign cksum_ok  = (cksum == q.cal[ssla_pkg::CKSUM_ADDR]);
  assign fuse_open = (q.aux[ssla_pkg::AUX_CH_FUSE] < ssla_pkg::FUSE_OPEN_LVL);
  assign temp_max  = (q.aux[ssla_pkg::AUX_CH_AMB] > q.aux[ssla_pkg::AUX_CH_HS]) ?
                     q.aux[ssla_pkg::AUX_CH_AMB] : q.aux[ssla_pkg::AUX_CH_HS];
  assign fan_sum   = {2'b00, temp_max} + {5'h00, q.aux[ssla_pkg::AUX_CH_VOLT][7:3]}
                   + {5'h00, q.aux[ssla_pkg::AUX_CH_CURR][7:3]};
  assign fan_drive = (fan_sum > 10'h0FF) ? 8'hFF : fan_sum[7:0];
  assign op        = q.cmd[ssla_pkg::OP_MSB:ssla_pkg::OP_LSB];
  assign addr      = q.cmd[ssla_pkg::ADDR_MSB:ssla_pkg::ADDR_LSB];
  assign val       = q.cmd[15:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.start = 1'b0;

    if (!PRI_CS_N && q.cs_n_prev) begin
      d.tx  = {q.reply, 8'h00};
      d.cnt = 5'h00;
    end else if (!PRI_CS_N) begin
      if (PRI_SCLK && !q.sclk_prev) begin
        d.rx = {q.rx[22:0], PRI_SDI};
        if (q.cnt != 5'h1F) begin
          d.cnt = q.cnt + 5'h01;
        end
      end
      if (!PRI_SCLK && q.sclk_prev) begin
        d.tx = {q.tx[22:0], 1'b0};
      end
    end
    if (PRI_CS_N && !q.cs_n_prev && q.cnt == 5'(ssla_pkg::FRAME_BITS) && !q.pend) begin
      d.pend = 1'b1;
      d.cmd  = q.rx;
    end
    d.sclk_prev = PRI_SCLK;
    d.cs_n_prev = PRI_CS_N;

    if (q.poll != 32'h0000_0000) begin
      d.poll = q.poll - 32'h0000_0001;
    end

    unique case (q.state)
      MS_IDLE: begin
        if (q.pend) begin
          d.job_host = 1'b1;
          d.pend     = 1'b0;
          case (op)
            ssla_pkg::OP_DAC_WRITE: begin
              d.pend  = 1'b1;
              d.start = 1'b1;
              d.state = MS_WAIT;
              if (!addr[1]) begin
                d.dev  = ssla_pkg::DEV_DAC12;
                d.word = {addr[1:0], 2'b00, val[11:0]};
              end else begin
                d.dev  = ssla_pkg::DEV_DAC8;
                d.word = {1'b0, addr[0], 6'h00, val[7:0]};
              end
            end
            ssla_pkg::OP_PREC_READ: begin
              d.pend  = 1'b1;
              d.mux   = addr[1:0];
              d.start = 1'b1;
              d.dev   = ssla_pkg::DEV_ADC16;
              d.word  = 16'h0000;
              d.state = MS_WAIT;
            end
            ssla_pkg::OP_AUX_READ: begin
              d.pend  = 1'b1;
              d.start = 1'b1;
              d.dev   = ssla_pkg::DEV_ADC8;
              d.word  = {addr[2:0], 13'h0000};
              d.state = MS_WAIT;
            end
            ssla_pkg::OP_STATUS:     d.reply = q.status;
            ssla_pkg::OP_PROT_CLEAR: d.ov_latch = 1'b0;
            ssla_pkg::OP_OUTPUT:     d.out_off = ~val[0];
            ssla_pkg::OP_CAL_UNLOCK: d.unlocked = (val == CAL_PASSWORD);
            ssla_pkg::OP_CAL_WRITE: begin
              if (q.unlocked && !CAL_PROTECT) begin
                d.cal[addr] = val;
              end
            end
            ssla_pkg::OP_CAL_READ:   d.reply = q.cal[addr];
            default: ;
          endcase
        end else if (q.poll == 32'h0000_0000) begin
          d.poll     = 32'(POLL_CYCLES - 1);
          d.job_host = 1'b0;
          d.step     = ssla_pkg::AUX_CH_CURR;
          d.start    = 1'b1;
          d.dev      = ssla_pkg::DEV_ADC8;
          d.word     = {ssla_pkg::AUX_CH_CURR, 13'h0000};
          d.state    = MS_WAIT;
        end
      end
      MS_WAIT: begin
        if (conv_done) begin
          d.state = MS_IDLE;
          if (q.job_host) begin
            d.pend = 1'b0;
            if (op == ssla_pkg::OP_PREC_READ) begin
              d.reply = conv_rx;
            end else if (op == ssla_pkg::OP_AUX_READ) begin
              d.reply = {8'h00, conv_rx[7:0]};
            end
          end else if (q.step < ssla_pkg::SCAN_FAN_STEP) begin
            d.aux[q.step] = conv_rx[7:0];
            d.step        = q.step + 3'h1;
            d.start       = 1'b1;
            d.state       = MS_WAIT;
            if (q.step == ssla_pkg::AUX_CH_FUSE) begin
              d.dev  = ssla_pkg::DEV_DAC8;
              d.word = {ssla_pkg::DAC8_CH_FAN, 6'h00, fan_drive};
            end else begin
              d.dev  = ssla_pkg::DEV_ADC8;
              d.word = {q.step + 3'h1, 13'h0000};
            end
          end
        end
      end
    endcase

    if (!OVERVOLTAGE_FLAG_N) begin
      d.ov_latch = 1'b1;
    end
    d.shutdown  = d.ov_latch | d.out_off;
    d.crowbar_n = ~d.ov_latch;

    d.status                         = 16'h0000;
    d.status[ssla_pkg::ST_CV]        = ~CONST_VOLTAGE_FLAG_N;
    d.status[ssla_pkg::ST_CC]        = ~CONST_CURRENT_FLAG_N;
    d.status[ssla_pkg::ST_OV]        = ~OVERVOLTAGE_FLAG_N;
    d.status[ssla_pkg::ST_OV_LATCH]  = q.ov_latch;
    d.status[ssla_pkg::ST_UNLOCKED]  = q.unlocked;
    d.status[ssla_pkg::ST_CKSUM_OK]  = cksum_ok;
    d.status[ssla_pkg::ST_FUSE_OPEN] = fuse_open;
    d.status[ssla_pkg::ST_OUT_OFF]   = q.shutdown;

    if (SYS_RST) begin
      d           = '0;
      d.state     = MS_IDLE;
      d.sclk_prev = 1'b0;
      d.cs_n_prev = 1'b1;
      d.out_off   = ssla_pkg::OUT_OFF_RESET;
      d.shutdown  = 1'b1;
      d.crowbar_n = 1'b1;
      d.aux       = {5{8'hFF}};
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Converter bus engine
  // ----------------------------------------------------------------
  ssla_conv_xfer u_xfer (
    .clk     (CLK),
    .rst     (SYS_RST),
    .start   (q.start),
    .dev     (q.dev),
    .word    (q.word),
    .miso    (CONV_MISO),
    .sclk    (CONV_SCLK),
    .mosi    (CONV_MOSI),
    .cs_n    (CONV_CS_N),
    .rx_word (conv_rx),
    .done    (conv_done)
  );

  assign PRI_SDO         = q.tx[23];
  assign PRI_BUSY        = q.pend;
  assign PREC_MUX_SEL    = q.mux;
  assign OUTPUT_SHUTDOWN = q.shutdown;
  assign CROWBAR_FIRE_N  = q.crowbar_n;
  assign STATUS          = q.status;

endmodule : ssla_top

`default_nettype wire

// ===== ssla_monitor.sv
// Port-level checker for the secondary-side logic array top.
// Assumes it is bound to ssla_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ssla_monitor #(
  parameter int POLL_CYCLES = 200
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PRI_CS_N,
  input wire logic        PRI_BUSY,
  input wire logic        CONV_SCLK,
  input wire logic [3:0]  CONV_CS_N,
  input wire logic        CONST_VOLTAGE_FLAG_N,
  input wire logic        CONST_CURRENT_FLAG_N,
  input wire logic        OVERVOLTAGE_FLAG_N,
  input wire logic        OUTPUT_SHUTDOWN,
  input wire logic        CROWBAR_FIRE_N,
  input wire logic [15:0] STATUS
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  ov_fire_a: assert property (!OVERVOLTAGE_FLAG_N |-> ##[1:3] !CROWBAR_FIRE_N)
    else $error("crowbar not fired after overvoltage");
  fire_shutdown_a: assert property (!CROWBAR_FIRE_N |-> OUTPUT_SHUTDOWN)
    else $error("output not shut down while crowbar fired");
  crowbar_hold_a: assert property ($fell(CROWBAR_FIRE_N) |-> !CROWBAR_FIRE_N [*8])
    else $error("crowbar released too early");
  crowbar_release_a: assert property ($rose(CROWBAR_FIRE_N) |-> $past(OVERVOLTAGE_FLAG_N)
    && ($past(PRI_BUSY) || $past(PRI_BUSY, 2) || $past(PRI_BUSY, 3)))
    else $error("crowbar released without a command");
  one_select_a: assert property ($onehot0(~CONV_CS_N))
    else $error("more than one converter selected");
  sclk_select_a: assert property (CONV_SCLK |-> CONV_CS_N != 4'hF)
    else $error("converter clock with no device selected");
  status_live_a: assert property (!$past(SYS_RST) |-> STATUS[2:0] ==
    ~$past({OVERVOLTAGE_FLAG_N, CONST_CURRENT_FLAG_N, CONST_VOLTAGE_FLAG_N}))
    else $error("status does not follow the mode lines");
  status_spare_a: assert property (STATUS[15:8] == 8'h00)
    else $error("unused status bits set");
  frame_busy_a: assert property ($rose(PRI_CS_N) && !PRI_BUSY |-> ##[1:3] PRI_BUSY)
    else $error("frame not taken");
endmodule : ssla_monitor

bind ssla_top ssla_monitor #(.POLL_CYCLES(POLL_CYCLES)) i_mon (
  .CLK, .SYS_RST, .PRI_CS_N, .PRI_BUSY, .CONV_SCLK, .CONV_CS_N, .CONST_VOLTAGE_FLAG_N,
  .CONST_CURRENT_FLAG_N, .OVERVOLTAGE_FLAG_N, .OUTPUT_SHUTDOWN, .CROWBAR_FIRE_N, .STATUS
);
`default_nettype wire

// ===== ssla_primary_model.sv
// Model of the primary processor on the isolated serial frame link.
// Assumes the caller enters its task just after a rising CLK edge.
`timescale 1ns/1ps
`default_nettype none

module ssla_primary_model (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    sdi  = 1'h0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Sends one frame MSB first and gathers the bits shifted back.
  task automatic send(input logic [23:0] frame, output logic [23:0] rx);
    rx = 24'h000000;
    step(1);
    cs_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      sdi = frame[i];
      step(2);
      rx[i] = sdo;
      sclk = 1'h1;
      step(2);
      sclk = 1'h0;
    end
    step(2);
    cs_n = 1'h1;
    sdi = ~sdi;
  endtask : send
endmodule : ssla_primary_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the secondary-side logic array.
// Assumes the primary model and a behavioural converter bus sit around the top.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int          POLL = 200;
  localparam logic [15:0] PW   = 16'h3C96;
  logic        clk = 1'h0, sys_rst = 1'h1, cs_n, sclk, sdi, sdo, busy;
  logic        c_sclk, c_mosi, c_miso = 1'h0, shutdown, crowbar_n;
  logic        cv_n = 1'h1, cc_n = 1'h1, ov_n = 1'h1, protect = 1'h1, sclk_q = 1'h0;
  logic [3:0]  c_cs_n, cs_q = 4'hF;
  logic [1:0]  mux;
  logic [15:0] status, shr, mosi_sr, dev_word [4];
  logic [7:0]  aux_val = 8'h30;
  logic [23:0] rx;
  int          mismatches = 0, compares = 0;

  always #5 clk = ~clk;

  ssla_primary_model i_pri (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  ssla_top #(.POLL_CYCLES(POLL), .CAL_PASSWORD(PW)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .PRI_CS_N(cs_n), .PRI_SCLK(sclk), .PRI_SDI(sdi),
    .PRI_SDO(sdo), .PRI_BUSY(busy), .CONV_SCLK(c_sclk), .CONV_MOSI(c_mosi),
    .CONV_MISO(c_miso), .CONV_CS_N(c_cs_n), .PREC_MUX_SEL(mux),
    .CONST_VOLTAGE_FLAG_N(cv_n), .CONST_CURRENT_FLAG_N(cc_n), .OVERVOLTAGE_FLAG_N(ov_n),
    .CAL_PROTECT(protect), .OUTPUT_SHUTDOWN(shutdown), .CROWBAR_FIRE_N(crowbar_n),
    .STATUS(status)
  );

  // ----------------------------------------------------------------
  // Converter bus devices
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    if (&c_cs_n) begin
      c_miso = ~c_miso;
      for (int d = 0; d < 4; d++) begin
        if (!cs_q[d]) dev_word[d] = mosi_sr;
      end
    end else if (&cs_q) begin
      shr = c_cs_n[2] ? {8'h00, aux_val} : 16'hA5C3;
      c_miso = shr[15];
    end else if (sclk_q && !c_sclk) begin
      shr = {shr[14:0], 1'h0};
      c_miso = shr[15];
    end else if (!sclk_q && c_sclk) begin
      mosi_sr = {mosi_sr[14:0], c_mosi};
    end
    cs_q = c_cs_n;
    sclk_q = c_sclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    i_pri.send({op, a, d}, rx);
    wait_clk(3);
    while (busy !== 1'h0) begin
      wait_clk(1);
      n++;
      if (n > 3000) begin
        mismatches++;
        give_verdict;
      end
    end
    wait_clk(2);
  endtask : cmd

  task automatic read_back(input logic [3:0] op, input logic [3:0] a, input logic [15:0] exp);
    cmd(op, a, 16'h0000);
    cmd(ssla_pkg::OP_STATUS, 4'h0, 16'h0000);
    chk16(rx[23:8], exp);
  endtask : read_back

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk1(shutdown, 1'h1);
    chk1(crowbar_n, 1'h1);
    chk16({12'h000, c_cs_n}, 16'h000F);
    chk1(status[ssla_pkg::ST_CKSUM_OK], 1'h1);
  endtask : t_reset

  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      {cc_n, cv_n} = i[1:0];
      wait_clk(2);
      chk16({13'h0000, status[2:0]}, {13'h0000, 1'h0, ~i[1:0]});
    end
    {cc_n, cv_n} = 2'h3;
  endtask : t_status

  task automatic t_set;
    logic [15:0] d;
    logic [15:0] w;
    for (int a = 0; a < 4; a++) begin
      d = {12'h0A5, 2'h3, a[1:0]};
      w = (a < 2) ? {a[1:0], 2'h0, d[11:0]} : {1'h0, a[0], 6'h00, d[7:0]};
      cmd(ssla_pkg::OP_DAC_WRITE, {2'h0, a[1:0]}, d);
      chk16(dev_word[a / 2], w);
    end
  endtask : t_set

  task automatic t_prec;
    for (int m = 0; m < 4; m++) begin
      cmd(ssla_pkg::OP_PREC_READ, {2'h0, m[1:0]}, 16'h0000);
      chk16({14'h0000, mux}, {14'h0000, m[1:0]});
      if (m > 0) chk16(rx[23:8], 16'hA5C3);
    end
  endtask : t_prec

  task automatic t_scan(input logic [7:0] a);
    logic [9:0] s;
    s = {2'h0, a} + {5'h00, a[7:3]} + {5'h00, a[7:3]};
    aux_val = a;
    wait_clk(2 * POLL + 900);
    chk16(dev_word[1], {8'h40, (s > 10'h0FF) ? 8'hFF : s[7:0]});
    chk1(status[ssla_pkg::ST_FUSE_OPEN], a < ssla_pkg::FUSE_OPEN_LVL);
    cmd(ssla_pkg::OP_AUX_READ, 4'h4, 16'h0000);
    chk16(dev_word[3], {ssla_pkg::AUX_CH_FUSE, 13'h0000});
    cmd(ssla_pkg::OP_STATUS, 4'h0, 16'h0000);
    chk16(rx[23:8], {8'h00, a});
  endtask : t_scan

  task automatic t_prot;
    cmd(ssla_pkg::OP_OUTPUT, 4'h0, 16'h0001);
    chk1(shutdown, 1'h0);
    chk1(status[ssla_pkg::ST_OUT_OFF], 1'h0);
    ov_n = 1'h0;
    wait_clk(4);
    chk1(crowbar_n, 1'h0);
    chk1(status[ssla_pkg::ST_OV], 1'h1);
    chk1(shutdown, 1'h1);
    chk1(status[ssla_pkg::ST_OV_LATCH], 1'h1);
    cmd(ssla_pkg::OP_PROT_CLEAR, 4'h0, 16'h0000);
    chk1(crowbar_n, 1'h0);
    ov_n = 1'h1;
    wait_clk(20);
    chk1(crowbar_n, 1'h0);
    cmd(ssla_pkg::OP_PROT_CLEAR, 4'h0, 16'h0000);
    chk1(crowbar_n, 1'h1);
    chk1(shutdown, 1'h0);
    cmd(ssla_pkg::OP_OUTPUT, 4'h0, 16'h0000);
    chk1(shutdown, 1'h1);
    chk1(status[ssla_pkg::ST_OUT_OFF], 1'h1);
  endtask : t_prot

  task automatic t_cal;
    cmd(ssla_pkg::OP_CAL_WRITE, 4'h0, 16'h1234);
    read_back(ssla_pkg::OP_CAL_READ, 4'h0, 16'h0000);
    cmd(ssla_pkg::OP_CAL_UNLOCK, 4'h0, PW ^ 16'h0001);
    chk1(status[ssla_pkg::ST_UNLOCKED], 1'h0);
    cmd(ssla_pkg::OP_CAL_UNLOCK, 4'h0, PW);
    chk1(status[ssla_pkg::ST_UNLOCKED], 1'h1);
    cmd(ssla_pkg::OP_CAL_WRITE, 4'h0, 16'h1234);
    read_back(ssla_pkg::OP_CAL_READ, 4'h0, 16'h0000);
    protect = 1'h0;
    cmd(ssla_pkg::OP_CAL_WRITE, 4'h0, 16'h1234);
    read_back(ssla_pkg::OP_CAL_READ, 4'h0, 16'h1234);
    chk1(status[ssla_pkg::ST_CKSUM_OK], 1'h0);
    cmd(ssla_pkg::OP_CAL_WRITE, ssla_pkg::CKSUM_ADDR, 16'h1234);
    chk1(status[ssla_pkg::ST_CKSUM_OK], 1'h1);
  endtask : t_cal

  initial begin
    wait_clk(16);
    sys_rst = 1'h0;
    wait_clk(1);
    t_reset;
    t_status;
    t_set;
    t_prec;
    t_scan(8'h30);
    t_scan(8'h50);
    t_scan(8'hF0);
    t_prot;
    t_cal;
    give_verdict;
  end
endmodule : tb
`default_nettype wire
